//--- rtl/isrt_pkg.sv
package isrt_pkg;

  // pixel array geometry
  localparam int unsigned ARRAY_COLS        = 2112;
  localparam int unsigned ARRAY_ROWS        = 1568;
  localparam logic [11:0] COL_FIRST_ACTIVE  = 12'h01c;
  localparam logic [11:0] COL_BLACK_RIGHT   = 12'h825;
  localparam logic [11:0] ROW_FIRST_ACTIVE  = 12'h010;
  localparam logic [11:0] ROW_BLACK_BOTTOM  = 12'h619;
  localparam logic [15:0] BLACK_TOP_ROWS    = 16'h0010;
  localparam logic [15:0] BLACK_LEFT_COLS   = 16'h001c;

  // read mode bit positions and addressing fields
  localparam int unsigned SHOW_BLACK_ROWS_BIT = 11;
  localparam int unsigned SHOW_BLACK_COLS_BIT = 7;
  localparam int unsigned SKIP_LSB            = 0;
  localparam int unsigned BIN_LSB             = 4;

  // blanking figures in pixel clocks
  localparam logic [15:0] P1_NORMAL   = 16'h014b;
  localparam logic [15:0] P1_BIN2     = 16'h02a1;
  localparam logic [15:0] P1_BIN3     = 16'h03e7;
  localparam logic [15:0] P2_NORMAL   = 16'h0026;
  localparam logic [15:0] P2_BIN2     = 16'h0016;
  localparam logic [15:0] P2_BIN3     = 16'h000e;
  localparam logic [15:0] HBLANK_MIN  = 16'h0015;
  localparam logic [15:0] SHUTTER_OVH = 16'h013c;

  // flash pulse length in pixel clocks
  localparam logic [7:0]  STROBE_CYCLES = 8'h10;

  // pin synchroniser reset: {tristate, trigger, standby}
  localparam logic [2:0]  PIN_SYNC_RST = 3'h5;

  // pixel colour codes
  localparam logic [1:0]  COLOR_GREEN_R = 2'h0;
  localparam logic [1:0]  COLOR_RED     = 2'h1;
  localparam logic [1:0]  COLOR_BLUE    = 2'h2;
  localparam logic [1:0]  COLOR_GREEN_B = 2'h3;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_WAIT  = 3'b010,
    ST_FRAME = 3'b100
  } isrt_state_t;

  typedef struct packed {
    logic [15:0] row_size_reg;
    logic [15:0] column_size_reg;
    logic [15:0] horizontal_blank_reg;
    logic [15:0] vertical_blank_reg;
    logic [15:0] first_read_mode_reg;
    logic [15:0] second_read_mode_reg;
    logic [15:0] row_addressing_reg;
    logic [15:0] column_addressing_reg;
    logic [15:0] shutter_width_high_reg;
    logic [15:0] shutter_width_low_reg;
    logic [15:0] shutter_delay;
    logic        snapshot_mode;
    logic [1:0]  lv_format;
  } isrt_cfg_t;

  localparam isrt_cfg_t CFG_RST = '{
    row_size_reg:          16'h05ff,
    column_size_reg:       16'h07ff,
    horizontal_blank_reg:  16'h008e,
    vertical_blank_reg:    16'h0019,
    first_read_mode_reg:   16'hc040,
    second_read_mode_reg:  16'h2000,
    row_addressing_reg:    16'h0000,
    column_addressing_reg: 16'h0000,
    shutter_width_high_reg: 16'h0000,
    shutter_width_low_reg: 16'h0619,
    shutter_delay:         16'h0000,
    snapshot_mode:         1'b0,
    lv_format:             2'h0
  };

  typedef struct packed {
    logic [15:0] t_act;
    logic [15:0] t_end;
    logic [15:0] row_len;
    logic [15:0] r_out;
    logic [19:0] rows_total;
    logic [2:0]  rskip;
    logic [2:0]  cskip;
    logic        brows;
    logic        bcols;
  } isrt_tim_t;

  typedef struct packed {
    isrt_state_t state;
    logic [15:0] hc;
    logic [19:0] row;
    logic [11:0] raddr;
    logic [11:0] arow;
    logic [11:0] acol;
    logic        lv;
    logic        fv;
    logic        bw;
    logic [7:0]  strobe_cnt;
    logic [13:0] bl_acc;
    isrt_tim_t   ft;
  } isrt_scan_t;

  typedef struct packed {
    logic [9:0] data;
    logic [1:0] color;
    logic       line;
    logic       image;
    logic       strobe;
    logic       off;
  } isrt_out_t;

endpackage : isrt_pkg

//--- rtl/isrt_readout.sv
`timescale 1ns/1ns
`default_nettype none

module isrt_readout #(
  parameter logic [7:0] STROBE_LEN = isrt_pkg::STROBE_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire isrt_pkg::isrt_cfg_t cfg,
  output logic                   cfg_pending,
  output logic                   frame_busy,
  output logic                   in_standby,
  input  wire logic              master_clock_in,
  input  wire logic              standby_pin,
  input  wire logic              trigger_pin,
  input  wire logic              out_tristate_pin,
  input  wire logic [9:0]        adc_data,
  output logic [11:0]            array_row,
  output logic [11:0]            array_col,
  output logic [1:0]             pixel_color,
  output logic [9:0]             pixel_bus,
  output logic                   line_active,
  output logic                   image_active,
  output logic                   flash_pulse,
  output logic                   pixel_out_clock,
  output logic                   out_oe_n
);
  import isrt_pkg::*;

  function automatic logic [15:0] isrt_even_count(input logic [15:0] size, input logic [2:0] skip);
    logic [15:0] n;
    logic [15:0] d;
    logic [15:0] q;
    n = size + 16'h0001;
    d = {13'h0000, skip} + 16'h0001;
    q = (n + d - 16'h0001) / d;
    q = q + {15'h0000, q[0]};
    return q;
  endfunction : isrt_even_count

  function automatic logic [11:0] isrt_addr_step(input logic [11:0] addr, input logic [2:0] skip,
                                                 input logic [11:0] first);
    logic [11:0] s;
    s = {9'h000, skip} + 12'h001;
    if (addr < first) begin
      s = 12'h001;
    end
    return addr + s;
  endfunction : isrt_addr_step

  // clock domain: clk, configuration handshake source
  isrt_cfg_t   hold;
  isrt_cfg_t   next_hold;
  logic        req;
  logic        next_req;
  logic        ack_meta;
  logic        ack_s;
  logic [1:0]  fv_sync;
  logic [1:0]  off_sync;

  // clock domain: master_clock_in
  logic [1:0]  lrst_sync;
  logic        lrst;
  logic [2:0]  pin_meta;
  logic [2:0]  pin_s;
  logic        req_meta;
  logic        req_s;
  isrt_cfg_t   shadow;
  isrt_cfg_t   next_shadow;
  logic        ack;
  logic        next_ack;
  isrt_tim_t   tim;
  isrt_tim_t   next_tim;
  isrt_scan_t  scan;
  isrt_scan_t  next_scan;
  isrt_out_t   outr;
  isrt_out_t   next_outr;
  logic        stby_s;
  logic        trig_s;
  logic        start;

  assign stby_s = pin_s[0];
  assign trig_s = pin_s[1];

  always_comb begin
    next_hold = hold;
    next_req  = req;
    if (req == ack_s && cfg != hold) begin
      next_hold = cfg;
      next_req  = ~req;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold     <= CFG_RST;
      req      <= 1'b0;
      ack_meta <= 1'b0;
      ack_s    <= 1'b0;
      fv_sync  <= 2'h0;
      off_sync <= 2'h3;
    end else begin
      hold     <= next_hold;
      req      <= next_req;
      ack_meta <= ack;
      ack_s    <= ack_meta;
      fv_sync  <= {fv_sync[0], outr.image};
      off_sync <= {off_sync[0], outr.off};
    end
  end

  assign cfg_pending = req != ack_s;
  assign frame_busy  = fv_sync[1];
  assign in_standby  = off_sync[1];

  // link reset: asserted at once, released on the link clock
  always_ff @(posedge master_clock_in or posedge rst) begin
    if (rst) begin
      lrst_sync <= 2'h3;
    end else begin
      lrst_sync <= {lrst_sync[0], 1'b0};
    end
  end

  assign lrst = lrst_sync[1];

  always_ff @(posedge master_clock_in or posedge lrst) begin
    if (lrst) begin
      pin_meta <= PIN_SYNC_RST;
      pin_s    <= PIN_SYNC_RST;
      req_meta <= 1'b0;
      req_s    <= 1'b0;
    end else begin
      pin_meta <= {out_tristate_pin, trigger_pin, standby_pin};
      pin_s    <= pin_meta;
      req_meta <= req;
      req_s    <= req_meta;
    end
  end

  // shadow configuration taken over by handshake
  always_comb begin
    next_shadow = shadow;
    next_ack    = ack;
    if (req_s != ack) begin
      next_shadow = hold;
      next_ack    = req_s;
    end
  end

  always_ff @(posedge master_clock_in or posedge lrst) begin
    if (lrst) begin
      shadow <= CFG_RST;
      ack    <= 1'b0;
    end else begin
      shadow <= next_shadow;
      ack    <= next_ack;
    end
  end

  // frame geometry derived from the shadow settings
  always_comb begin
    logic [15:0] rows_a;
    logic [15:0] cols_a;
    logic [15:0] p1;
    logic [15:0] p2;
    logic [15:0] p3;
    logic [15:0] p4;
    logic [15:0] long_a;
    logic [15:0] long_b;
    logic [19:0] sw;
    logic [19:0] vrows;
    logic [1:0]  rbin;
    logic [1:0]  cbin;
    rows_a = 16'h0000;
    cols_a = 16'h0000;
    p1     = P1_NORMAL;
    p2     = P2_NORMAL;
    rbin   = shadow.row_addressing_reg[BIN_LSB +: 2];
    cbin   = shadow.column_addressing_reg[BIN_LSB +: 2];
    next_tim.rskip = shadow.row_addressing_reg[SKIP_LSB +: 3];
    next_tim.cskip = shadow.column_addressing_reg[SKIP_LSB +: 3];
    next_tim.brows = shadow.second_read_mode_reg[SHOW_BLACK_ROWS_BIT];
    next_tim.bcols = shadow.first_read_mode_reg[SHOW_BLACK_COLS_BIT];
    rows_a = isrt_even_count(shadow.row_size_reg, next_tim.rskip);
    cols_a = isrt_even_count(shadow.column_size_reg, next_tim.cskip);
    if (next_tim.brows) begin
      rows_a = rows_a + BLACK_TOP_ROWS;
    end
    if (next_tim.bcols) begin
      cols_a = cols_a + BLACK_LEFT_COLS;
    end
    unique case (rbin)
      2'h1:    p1 = P1_BIN2;
      2'h2:    p1 = P1_BIN3;
      default: p1 = P1_NORMAL;
    endcase
    unique case (cbin)
      2'h1:    p2 = P2_BIN2;
      2'h2:    p2 = P2_BIN3;
      default: p2 = P2_NORMAL;
    endcase
    p3 = shadow.horizontal_blank_reg;
    if (p3 < HBLANK_MIN) begin
      p3 = HBLANK_MIN;
    end
    p4 = shadow.shutter_delay + 16'(SHUTTER_OVH * ({14'h0000, cbin} + 16'h0001));
    long_a = cols_a + p1 + p2 + p3;
    long_b = p1 + p4;
    next_tim.row_len = (long_a > long_b) ? long_a : long_b;
    next_tim.t_act   = p1 + p2;
    next_tim.t_end   = p1 + p2 + cols_a;
    next_tim.r_out   = rows_a;
    sw    = {shadow.shutter_width_high_reg[3:0], shadow.shutter_width_low_reg};
    vrows = {4'h0, rows_a} + {4'h0, shadow.vertical_blank_reg} + 20'h00001;
    next_tim.rows_total = (sw > vrows) ? sw : vrows;
  end

  always_ff @(posedge master_clock_in or posedge lrst) begin
    if (lrst) begin
      tim <= '0;
    end else begin
      tim <= next_tim;
    end
  end

  // scan sequencer
  always_comb begin
    logic in_frame;
    logic hwin;
    logic vis_row;
    in_frame  = 1'b0;
    hwin      = 1'b0;
    vis_row   = 1'b0;
    start     = 1'b0;
    next_scan = scan;
    unique case (scan.state)
      ST_OFF: begin
        if (!stby_s) begin
          if (shadow.snapshot_mode) begin
            next_scan.state = ST_WAIT;
          end else begin
            start = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        if (stby_s) begin
          next_scan.state = ST_OFF;
        end else if (trig_s) begin
          start = 1'b1;
        end
      end
      ST_FRAME: begin
        if (stby_s) begin
          next_scan.state = ST_OFF;
        end else if (scan.hc == scan.ft.row_len - 16'h0001) begin
          next_scan.hc  = 16'h0000;
          next_scan.row = scan.row + 20'h00001;
          next_scan.raddr = isrt_addr_step(scan.raddr, scan.ft.rskip, ROW_FIRST_ACTIVE);
          if (scan.row == scan.ft.rows_total - 20'h00001) begin
            if (shadow.snapshot_mode) begin
              next_scan.state = ST_WAIT;
            end else begin
              start = 1'b1;
            end
          end
        end else begin
          next_scan.hc = scan.hc + 16'h0001;
        end
      end
    endcase
    if (start) begin
      next_scan.state      = ST_FRAME;
      next_scan.hc         = 16'h0000;
      next_scan.row        = 20'h00000;
      next_scan.ft         = tim;
      next_scan.raddr      = tim.brows ? 12'h000 : ROW_FIRST_ACTIVE;
      next_scan.strobe_cnt = STROBE_LEN;
    end else if (scan.strobe_cnt != 8'h00) begin
      next_scan.strobe_cnt = scan.strobe_cnt - 8'h01;
    end
    in_frame = next_scan.state == ST_FRAME;
    vis_row  = next_scan.row < {4'h0, next_scan.ft.r_out};
    hwin     = next_scan.hc >= next_scan.ft.t_act && next_scan.hc < next_scan.ft.t_end;
    next_scan.lv = in_frame && vis_row && hwin;
    next_scan.bw = in_frame && !vis_row && hwin;
    next_scan.fv = in_frame && vis_row &&
                   !(next_scan.row == {4'h0, next_scan.ft.r_out} - 20'h00001 &&
                     next_scan.hc >= next_scan.ft.t_end);
    if (next_scan.hc == next_scan.ft.t_act) begin
      next_scan.acol = next_scan.ft.bcols ? 12'h000 : COL_FIRST_ACTIVE;
    end else if (hwin) begin
      next_scan.acol = isrt_addr_step(scan.acol, next_scan.ft.cskip, COL_FIRST_ACTIVE);
    end
    // outside the visible rows the array walks its top black rows
    next_scan.arow = vis_row ? next_scan.raddr : {8'h00, next_scan.row[3:0]};
    if (scan.bw) begin
      next_scan.bl_acc = scan.bl_acc + {4'h0, adc_data} - {4'h0, scan.bl_acc[13:4]};
    end
  end

  always_ff @(posedge master_clock_in or posedge lrst) begin
    if (lrst) begin
      scan <= '{state: ST_OFF, default: '0};
    end else begin
      scan <= next_scan;
    end
  end

  // output stage, registered one clock behind the array address
  always_comb begin
    logic [9:0] level;
    level     = scan.bl_acc[13:4];
    next_outr = '0;
    next_outr.off   = scan.state == ST_OFF;
    next_outr.image = scan.fv;
    next_outr.strobe = scan.strobe_cnt != 8'h00;
    if (scan.lv) begin
      next_outr.data = (adc_data > level) ? adc_data - level : 10'h000;
    end
    unique case (shadow.lv_format)
      2'h1:    next_outr.line = scan.fv;
      2'h2:    next_outr.line = scan.fv ^ scan.lv;
      default: next_outr.line = scan.lv;
    endcase
    unique case ({scan.arow[0], scan.acol[0]})
      2'b00:   next_outr.color = COLOR_GREEN_R;
      2'b01:   next_outr.color = COLOR_RED;
      2'b10:   next_outr.color = COLOR_BLUE;
      default: next_outr.color = COLOR_GREEN_B;
    endcase
  end

  always_ff @(posedge master_clock_in or posedge lrst) begin
    if (lrst) begin
      outr <= '{off: 1'b1, default: '0};
    end else begin
      outr <= next_outr;
    end
  end

  assign pixel_bus       = outr.data;
  assign line_active     = outr.line;
  assign image_active    = outr.image;
  assign flash_pulse     = outr.strobe;
  assign pixel_color     = outr.color;
  assign array_row       = scan.arow;
  assign array_col       = scan.acol;
  assign pixel_out_clock = master_clock_in;
  assign out_oe_n        = pin_s[2];

endmodule : isrt_readout

`default_nettype wire

//--- testbench/isrt_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module isrt_monitor #(
  parameter logic [7:0] STROBE_LEN = 8'h10
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       master_clock_in,
  input wire logic       standby_pin,
  input wire logic       out_tristate_pin,
  input wire logic [9:0] pixel_bus,
  input wire logic       line_active,
  input wire logic       image_active,
  input wire logic       flash_pulse,
  input wire logic       pixel_out_clock,
  input wire logic       out_oe_n
);
  logic [7:0] fcnt;
  logic [7:0] next_fcnt;
  always_comb next_fcnt = flash_pulse ? fcnt + 8'h01 : 8'h00;
  always_ff @(posedge master_clock_in or posedge rst) begin
    if (rst) fcnt <= 8'h00;
    else fcnt <= next_fcnt;
  end
  property p_oe_off;
    @(posedge master_clock_in) disable iff (rst) out_tristate_pin [*4] |-> out_oe_n;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("outputs driven while tristate pin high");
  property p_oe_on;
    @(posedge master_clock_in) disable iff (rst) !out_tristate_pin [*5] |-> !out_oe_n;
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("outputs released while tristate pin low");
  property p_pclk;
    @(posedge clk) disable iff (rst) pixel_out_clock == master_clock_in;
  endproperty
  a_pclk: assert property (p_pclk)
    else $error("pixel clock differs from master clock");
  property p_line_in_img;
    @(posedge master_clock_in) disable iff (rst) line_active |-> image_active;
  endproperty
  a_line_in_img: assert property (p_line_in_img)
    else $error("row active outside image active");
  property p_bus_idle;
    @(posedge master_clock_in) disable iff (rst) !line_active |-> pixel_bus == 10'h000;
  endproperty
  a_bus_idle: assert property (p_bus_idle)
    else $error("pixel bus nonzero outside row");
  property p_flash_start;
    @(posedge master_clock_in) disable iff (rst) $rose(image_active) |-> flash_pulse;
  endproperty
  a_flash_start: assert property (p_flash_start)
    else $error("no flash at frame start");
  property p_flash_len;
    @(posedge master_clock_in) disable iff (rst) $fell(flash_pulse) |-> fcnt == STROBE_LEN;
  endproperty
  a_flash_len: assert property (p_flash_len)
    else $error("flash pulse length wrong");
  property p_standby;
    @(posedge master_clock_in) disable iff (rst) standby_pin [*6] |-> !image_active && !line_active;
  endproperty
  a_standby: assert property (p_standby)
    else $error("video active in standby");
  property p_hblank;
    @(posedge master_clock_in) disable iff (rst)
      $fell(line_active) && image_active |-> !line_active [*8] ##1 image_active;
  endproperty
  a_hblank: assert property (p_hblank)
    else $error("horizontal blank too short or frame dropped");
  property p_vstart;
    @(posedge master_clock_in) disable iff (rst) $rose(image_active) |-> !line_active [*8];
  endproperty
  a_vstart: assert property (p_vstart)
    else $error("row active too early in frame");
  property p_min_line;
    @(posedge master_clock_in) disable iff (rst) $rose(line_active) |-> line_active [*2];
  endproperty
  a_min_line: assert property (p_min_line)
    else $error("row shorter than two pixels");
endmodule : isrt_monitor
bind isrt_readout isrt_monitor #(.STROBE_LEN(STROBE_LEN)) i_isrt_monitor (.clk(clk), .rst(rst),
  .master_clock_in(master_clock_in), .standby_pin(standby_pin), .out_tristate_pin(out_tristate_pin),
  .pixel_bus(pixel_bus), .line_active(line_active), .image_active(image_active), .flash_pulse(flash_pulse),
  .pixel_out_clock(pixel_out_clock), .out_oe_n(out_oe_n));
`default_nettype wire

//--- testbench/isrt_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module isrt_host_model (
  input wire logic       pixel_out_clock,
  input wire logic       rst,
  input wire logic       line_active,
  input wire logic       image_active,
  input wire logic [1:0] pixel_color,
  input wire logic [9:0] pixel_bus,
  output int             frames,
  output int             lines,
  output int             words,
  output int             lead,
  output int             gap,
  output int             period,
  output logic [7:0]     colors,
  output logic [9:0]     last_word
);
  int   cnt;
  int   fcnt;
  logic lv_q;
  logic fv_q;
  // capture on falling pixel clock edge
  always @(negedge pixel_out_clock or posedge rst) begin
    if (rst) begin
      {frames, lines, words, lead, gap, period, cnt, fcnt} <= '0;
      {lv_q, fv_q, colors, last_word} <= '0;
    end else begin
      lv_q <= line_active;
      fv_q <= image_active;
      cnt <= (line_active != lv_q || (image_active && !fv_q)) ? 1 : cnt + 1;
      fcnt <= (image_active && !fv_q) ? 1 : fcnt + 1;
      if (image_active && !fv_q) begin
        lines <= 0;
        period <= fcnt;
      end
      if (line_active && !lv_q) begin
        if (lines == 0) lead <= cnt;
        else gap <= cnt;
      end
      if (line_active) words <= lv_q ? words + 1 : 1;
      if (line_active) last_word <= pixel_bus;
      if (line_active && lines < 2 && (!lv_q || words == 1)) colors <= {colors[5:0], pixel_color};
      if (!line_active && lv_q) lines <= lines + 1;
      if (!image_active && fv_q) frames <= frames + 1;
    end
  end
endmodule : isrt_host_model
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %0d got %0d", n, e, g); end end
module tb_top;
  import isrt_pkg::*;
  logic       clk, rst, mclk, stby, trig, tri_pin, pend, busy, in_stby, lv, fv, flash, pclk, oe_n;
  isrt_cfg_t  cfg;
  logic [9:0] adc, pbus, word;
  logic [11:0] arow, acol;
  logic [1:0] color;
  logic [7:0] colors;
  int         frames, lines, words, lead, gap, period, err_total, checks_done, cyc;
  int rsz[3] = '{4, 7, 3}, rsk[3] = '{0, 1, 0}, csz[3] = '{7, 6, 7}, csk[3] = '{0, 1, 0};
  int hb[3] = '{21, 700, 5}, sw[3] = '{1, 1, 12}, p1[3] = '{331, 673, 999}, p2[3] = '{38, 22, 14};
  assign adc = (arow < 12'h010) ? 10'h010 : 10'h200;
  isrt_readout #(.STROBE_LEN(8'h04)) i_isrt_readout (.clk(clk), .rst(rst), .cfg(cfg), .cfg_pending(pend),
    .frame_busy(busy), .in_standby(in_stby), .master_clock_in(mclk), .standby_pin(stby), .trigger_pin(trig),
    .out_tristate_pin(tri_pin), .adc_data(adc), .array_row(arow), .array_col(acol), .pixel_color(color),
    .pixel_bus(pbus), .line_active(lv), .image_active(fv), .flash_pulse(flash), .pixel_out_clock(pclk),
    .out_oe_n(oe_n));
  isrt_host_model i_isrt_host_model (.pixel_out_clock(pclk), .rst(rst), .line_active(lv), .image_active(fv),
    .pixel_color(color), .pixel_bus(pbus), .frames(frames), .lines(lines), .words(words), .lead(lead),
    .gap(gap), .period(period), .colors(colors), .last_word(word));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  initial begin
    mclk = 0;
    #2;
    forever #6 mclk = ~mclk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      complete_run();
    end
  end
  function automatic int ev(input int n, input int d);
    int q;
    q = (n + d - 1) / d;
    return q + q % 2;
  endfunction : ev
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask : settle
  task automatic set_cfg(input int i);
    @(posedge clk);
    cfg.row_size_reg <= 16'(rsz[i]);
    cfg.column_size_reg <= 16'(csz[i]);
    cfg.horizontal_blank_reg <= 16'(hb[i]);
    cfg.vertical_blank_reg <= 16'h0003;
    cfg.row_addressing_reg <= 16'(i * 16 + rsk[i]);
    cfg.column_addressing_reg <= 16'(i * 16 + csk[i]);
    cfg.shutter_width_low_reg <= 16'(sw[i]);
  endtask : set_cfg
  task automatic wait_cfg();
    settle(3);
    for (int k = 0; k < 100 && pend !== 1'b0; k++) settle(1);
  endtask : wait_cfg
  task automatic wait_frames(input int n);
    int f;
    f = frames;
    for (int k = 0; k < 20000 && frames < f + n; k++) settle(1);
  endtask : wait_frames
  task automatic t_reset();
    settle(11);
    `CHK("in_standby", 1'b1, in_stby)
    `CHK("oe_n_rst", 1'b1, oe_n)
    `CHK("image_rst", 1'b0, fv)
    @(posedge clk) rst <= 1'b0;
    wait_cfg();
    `CHK("oe_n_hiz", 1'b1, oe_n)
    @(posedge clk) tri_pin <= 1'b0;
    settle(3);
    `CHK("oe_n_drive", 1'b0, oe_n)
    $display("done t_reset");
  endtask : t_reset
  task automatic t_geom(input int i);
    int r, a, rl;
    r = ev(rsz[i] + 1, rsk[i] + 1);
    a = ev(csz[i] + 1, csk[i] + 1);
    rl = a + p1[i] + p2[i] + (hb[i] < 21 ? 21 : hb[i]);
    if (p1[i] + 316 * (i + 1) > rl) rl = p1[i] + 316 * (i + 1);
    set_cfg(i);
    @(posedge clk) stby <= 1'b0;
    wait_cfg();
    wait_frames(3);
    `CHK("words", a, words)
    `CHK("lines", r, lines)
    `CHK("lead", p1[i] + p2[i], lead)
    `CHK("gap", rl - a, gap)
    `CHK("period", (sw[i] > r + 4 ? sw[i] : r + 4) * rl, period)
    if (i == 0) `CHK("colors", 8'h1b, colors)
    if (i == 0) `CHK("pixel", 10'h1f0, word)
    $display("done t_geom %0d", i);
  endtask : t_geom
  task automatic t_standby();
    @(posedge clk) stby <= 1'b1;
    settle(10);
    `CHK("stby_on", 1'b1, in_stby)
    `CHK("stby_img", 1'b0, fv)
    @(posedge clk) stby <= 1'b0;
    wait_frames(1);
    `CHK("stby_off", 1'b0, in_stby)
    $display("done t_standby");
  endtask : t_standby
  task automatic t_snap();
    int f;
    @(posedge clk) cfg.snapshot_mode <= 1'b1;
    wait_cfg();
    settle(1000);
    f = frames;
    settle(3000);
    `CHK("snap_idle", f, frames)
    `CHK("busy_idle", 1'b0, busy)
    @(posedge clk) trig <= 1'b1;
    for (int k = 0; k < 100 && fv !== 1'b1; k++) settle(1);
    @(posedge clk) trig <= 1'b0;
    settle(1);
    `CHK("busy", 1'b1, busy)
    settle(3000);
    `CHK("snap_one", f + 1, frames)
    $display("done t_snap");
  endtask : t_snap
  task automatic t_reset2();
    int seen;
    seen = 0;
    @(posedge clk) stby <= 1'b1;
    @(posedge clk) rst <= 1'b1;
    settle(4);
    `CHK("oe_n_rst2", 1'b1, oe_n)
    @(posedge clk) rst <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      settle(1);
      if (pend === 1'b1) seen = 1;
    end
    `CHK("cfg_defaults", 1, seen)
    $display("done t_reset2");
  endtask : t_reset2
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  initial begin
    {rst, stby, tri_pin, trig} = 4'b1110;
    {err_total, checks_done, cyc} = '0;
    cfg = CFG_RST;
    set_cfg(0);
    t_reset();
    for (int i = 2; i >= 0; i--) t_geom(i);
    t_standby();
    t_snap();
    t_reset2();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
